// ==== core/sync_cmd_pkg.sv ====
// How it works
// RULE1 - query code 0041H arrives high byte first, then protocol and antenna bytes
// RULE2 - query answer echoes 00H 41H, then zero, protocol/config byte, antenna byte
// RULE3 - protocol field reports the secondary sequence protocol; 4 means Title 21
// RULE4 - configuration field is 0 for no acknowledge, 1 for acknowledge
// RULE5 - antenna number reported lies between zero and 03H
// RULE6 - host sets the role with code 0045H, then mode byte and count byte
// RULE7 - mode bits: 0 slave, 1 master, 2 GPS secondary, 3 GPS primary
// RULE8 - host sets exactly one role bit; combinations are not allowed
// RULE9 - role command answer echoes 00H 45H only
// RULE10 - count sets this reader's takeover place when sync or 1-pps is lost
// RULE11 - slave select count never exceeds 26
// RULE12 - master with count 0 never follows; slaves take over in ascending count
// RULE13 - GPS secondary count 1 takes over; faulted primary follows with its count
// RULE14 - GPS primary with count 0 never follows; slaves succeed it in order
// RULE15 - host keeps delay plus duration strictly below the sync period
// RULE16 - host resets the reader after changing the secondary sequence
// RULE17 - lowest surviving nonzero count takes pulse generation; others stay followers; here counts whose slot ends before its first pulse also take over
package sync_cmd_pkg;

  localparam logic [7:0] CODE_HI       = 8'h00;
  localparam logic [7:0] CODE_QUERY_LO = 8'h41;
  localparam logic [7:0] CODE_ROLE_LO  = 8'h45;
  localparam logic [7:0] RESERVED_BYTE = 8'h00;

  localparam logic [3:0] PROTO_TITLE21 = 4'h4;
  localparam logic       ACK_NONE      = 1'b0;
  localparam logic       ACK_SEND      = 1'b1;
  localparam logic [7:0] ANTENNA_MAX   = 8'h03;

  localparam logic [3:0] MODE_NONE     = 4'h0;
  localparam logic [3:0] MODE_SLAVE    = 4'h1;
  localparam logic [3:0] MODE_MASTER   = 4'h2;
  localparam logic [3:0] MODE_GPS_SEC  = 4'h4;
  localparam logic [3:0] MODE_GPS_PRI  = 4'h8;
  localparam logic [7:0] MAX_COUNT     = 8'h1A;

  localparam logic [2:0] QUERY_LAST_IDX = 3'h4;
  localparam logic [2:0] ROLE_LAST_IDX  = 3'h1;
  localparam logic [2:0] IDX_CODE_LO    = 3'h1;
  localparam logic [2:0] IDX_RESERVED   = 3'h2;
  localparam logic [2:0] IDX_SEQ        = 3'h3;

  localparam int CNT_W = 27;

  // times in microseconds, counts derived at the 40 MHz clock
  localparam int unsigned CLK_MHZ         = 40;
  localparam int unsigned SYNC_PERIOD_US  = 20000;
  localparam int unsigned SYNC_LOSS_US    = 40000;
  localparam int unsigned PPS_LOSS_US     = 2000000;
  localparam int unsigned SLOT_US         = 1000;
  localparam int unsigned PULSE_US        = 100;
  localparam int unsigned SYNC_PERIOD_CYC = SYNC_PERIOD_US * CLK_MHZ;
  localparam int unsigned SYNC_LOSS_CYC   = SYNC_LOSS_US * CLK_MHZ;
  localparam int unsigned PPS_LOSS_CYC    = PPS_LOSS_US * CLK_MHZ;
  localparam int unsigned SLOT_CYC        = SLOT_US * CLK_MHZ;
  localparam int unsigned PULSE_CYC       = PULSE_US * CLK_MHZ;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_CODE_LO = 3'b001,
    ST_ARG0    = 3'b010,
    ST_ARG1    = 3'b011,
    ST_SEND    = 3'b100
  } cmd_state_t;

endpackage

// ==== core/loss_detector.sv ====
`timescale 1ns/1ps
module loss_detector #(
  parameter int unsigned TIMEOUT_CYC = 16
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // asynchronous pin
  input  wire logic pin,
  // results
  output logic      edge_pulse,
  output logic      lost
);

  logic                          meta_reg;
  logic                          sync_reg;
  logic                          prev_reg;
  logic [sync_cmd_pkg::CNT_W-1:0] cnt_reg;
  logic [sync_cmd_pkg::CNT_W-1:0] cnt_next;
  logic                          lost_reg;
  logic                          lost_next;

  assign edge_pulse = sync_reg & ~prev_reg;
  assign lost       = lost_reg;

  always_comb begin
    cnt_next  = cnt_reg;
    lost_next = lost_reg;
    if (edge_pulse) begin
      cnt_next  = '0;
      lost_next = 1'b0;
    end else if (cnt_reg == sync_cmd_pkg::CNT_W'(TIMEOUT_CYC - 1)) begin
      lost_next = 1'b1;
    end else begin
      cnt_next = cnt_reg + 1'b1;
    end
  end

  // meta_reg feeds sync_reg only
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
      cnt_reg  <= '0;
      lost_reg <= 1'b0;
    end else begin
      meta_reg <= pin;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
      cnt_reg  <= cnt_next;
      lost_reg <= lost_next;
    end
  end

endmodule

// ==== core/sync_cmd_unit.sv ====
`timescale 1ns/1ps
module sync_cmd_unit #(
  parameter int unsigned SYNC_PERIOD_CYC = sync_cmd_pkg::SYNC_PERIOD_CYC,
  parameter int unsigned SYNC_LOSS_CYC   = sync_cmd_pkg::SYNC_LOSS_CYC,
  parameter int unsigned PPS_LOSS_CYC    = sync_cmd_pkg::PPS_LOSS_CYC,
  parameter int unsigned SLOT_CYC        = sync_cmd_pkg::SLOT_CYC,
  parameter int unsigned PULSE_CYC       = sync_cmd_pkg::PULSE_CYC
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // host command bytes
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_byte,
  // response bytes
  input  wire logic       tx_ready,
  output logic            tx_valid,
  output logic      [7:0] tx_byte,
  // stored secondary tag sequence
  input  wire logic [3:0] seq_protocol,
  input  wire logic       seq_ack,
  input  wire logic [1:0] seq_antenna,
  // sync pin and gps pulse
  input  wire logic       sync_in,
  output logic            sync_out,
  output logic            sync_oe,
  input  wire logic       pps_in,
  // status
  output logic      [3:0] sync_role,
  output logic      [7:0] slave_count,
  output logic            pulse_master,
  output logic            mode_rejected
);

  function automatic logic role_valid(input logic [7:0] mode, input logic [7:0] cnt);
    role_valid = $onehot(mode[3:0]) && (cnt <= sync_cmd_pkg::MAX_COUNT);
  endfunction

  function automatic logic [7:0] resp_byte(input logic [7:0] cmd, input logic [2:0] idx,
                                           input logic [7:0] seq, input logic [7:0] ant);
    if (idx == '0) begin
      resp_byte = sync_cmd_pkg::CODE_HI;
    end else if (idx == sync_cmd_pkg::IDX_CODE_LO) begin
      resp_byte = cmd;
    end else if (idx == sync_cmd_pkg::IDX_RESERVED) begin
      resp_byte = sync_cmd_pkg::RESERVED_BYTE;
    end else if (idx == sync_cmd_pkg::IDX_SEQ) begin
      resp_byte = seq;
    end else begin
      resp_byte = ant;
    end
  endfunction

  logic sync_edge, sync_lost;
  logic pps_edge,  pps_lost;

  loss_detector #(.TIMEOUT_CYC(SYNC_LOSS_CYC)) u_sync_mon (
    .clk        (clk),
    .reset_n    (reset_n),
    .pin        (sync_in),
    .edge_pulse (sync_edge),
    .lost       (sync_lost)
  );

  loss_detector #(.TIMEOUT_CYC(PPS_LOSS_CYC)) u_pps_mon (
    .clk        (clk),
    .reset_n    (reset_n),
    .pin        (pps_in),
    .edge_pulse (pps_edge),
    .lost       (pps_lost)
  );

  // command parser and responder
  sync_cmd_pkg::cmd_state_t state_reg, state_next;
  logic [7:0] cmd_reg,     cmd_next;
  logic [7:0] arg0_reg,    arg0_next;
  logic [2:0] idx_reg,     idx_next;
  logic [7:0] seq_reg,     seq_next;
  logic [7:0] ant_reg,     ant_next;
  logic       tx_valid_reg, tx_valid_next;
  logic [7:0] tx_byte_reg,  tx_byte_next;
  logic [3:0] role_reg,    role_next;
  logic [7:0] count_reg,   count_next;
  logic       reject_reg,  reject_next;
  logic       role_write;
  logic [2:0] last_idx;

  assign last_idx = (cmd_reg == sync_cmd_pkg::CODE_QUERY_LO) ? sync_cmd_pkg::QUERY_LAST_IDX
                                                               : sync_cmd_pkg::ROLE_LAST_IDX;

  always_comb begin
    state_next    = state_reg;
    cmd_next      = cmd_reg;
    arg0_next     = arg0_reg;
    idx_next      = idx_reg;
    seq_next      = seq_reg;
    ant_next      = ant_reg;
    tx_valid_next = tx_valid_reg;
    tx_byte_next  = tx_byte_reg;
    role_next     = role_reg;
    count_next    = count_reg;
    reject_next   = 1'b0;
    role_write    = 1'b0;
    case (state_reg)
      sync_cmd_pkg::ST_IDLE: begin
        if (rx_valid && rx_byte == sync_cmd_pkg::CODE_HI) begin // see RULE1
          state_next = sync_cmd_pkg::ST_CODE_LO;
        end
      end
      sync_cmd_pkg::ST_CODE_LO: begin
        if (rx_valid) begin
          if (rx_byte == sync_cmd_pkg::CODE_QUERY_LO || rx_byte == sync_cmd_pkg::CODE_ROLE_LO) begin
            cmd_next   = rx_byte; // see RULE1
            state_next = sync_cmd_pkg::ST_ARG0;
          end else begin
            state_next = sync_cmd_pkg::ST_IDLE;
          end
        end
      end
      sync_cmd_pkg::ST_ARG0: begin
        if (rx_valid) begin
          arg0_next  = rx_byte;
          state_next = sync_cmd_pkg::ST_ARG1;
        end
      end
      sync_cmd_pkg::ST_ARG1: begin
        if (rx_valid) begin
          if (cmd_reg == sync_cmd_pkg::CODE_ROLE_LO) begin
            // bad role or count keeps the old setting but is still echoed
            if (role_valid(arg0_reg, rx_byte)) begin // see RULE7 see RULE11
              role_next  = arg0_reg[3:0];
              count_next = rx_byte; // see RULE10
              role_write = 1'b1;
            end else begin
              reject_next = 1'b1;
            end
          end else begin
            // snapshot so a mid-answer change cannot tear the reply
            seq_next = {seq_protocol, 3'h0, seq_ack}; // see RULE3 see RULE4
            ant_next = {6'h00, seq_antenna}; // see RULE5
          end
          idx_next      = '0;
          tx_valid_next = 1'b1;
          tx_byte_next  = sync_cmd_pkg::CODE_HI; // see RULE2 see RULE9
          state_next    = sync_cmd_pkg::ST_SEND;
        end
      end
      sync_cmd_pkg::ST_SEND: begin
        if (tx_ready) begin
          if (idx_reg == last_idx) begin // see RULE9
            tx_valid_next = 1'b0;
            state_next    = sync_cmd_pkg::ST_IDLE;
          end else begin
            idx_next     = idx_reg + 1'b1;
            tx_byte_next = resp_byte(cmd_reg, idx_reg + 1'b1, seq_reg, ant_reg); // see RULE2
          end
        end
      end
      default: begin
        state_next    = sync_cmd_pkg::ST_IDLE;
        tx_valid_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg    <= sync_cmd_pkg::ST_IDLE;
      cmd_reg      <= sync_cmd_pkg::CODE_HI;
      arg0_reg     <= 8'h00;
      idx_reg      <= 3'h0;
      seq_reg      <= 8'h00;
      ant_reg      <= 8'h00;
      tx_valid_reg <= 1'b0;
      tx_byte_reg  <= 8'h00;
      role_reg     <= sync_cmd_pkg::MODE_NONE;
      count_reg    <= 8'h00;
      reject_reg   <= 1'b0;
    end else begin
      state_reg    <= state_next;
      cmd_reg      <= cmd_next;
      arg0_reg     <= arg0_next;
      idx_reg      <= idx_next;
      seq_reg      <= seq_next;
      ant_reg      <= ant_next;
      tx_valid_reg <= tx_valid_next;
      tx_byte_reg  <= tx_byte_next;
      role_reg     <= role_next;
      count_reg    <= count_next;
      reject_reg   <= reject_next;
    end
  end

  // pulse generation and failover
  logic                          base_gen;
  logic                          gen_reg,      gen_next;
  logic                          take_reg,     take_next;
  logic                          bo_act_reg,   bo_act_next;
  logic [sync_cmd_pkg::CNT_W-1:0] bo_cnt_reg,   bo_cnt_next;
  logic [sync_cmd_pkg::CNT_W-1:0] per_cnt_reg,  per_cnt_next;
  logic [sync_cmd_pkg::CNT_W-1:0] pulse_cnt_reg, pulse_cnt_next;
  logic                          fire;
  logic                          drive_reg,    drive_next;

  // a faulted primary with a nonzero count drops to follower
  assign base_gen = (role_reg == sync_cmd_pkg::MODE_MASTER && count_reg == 8'h00) // see RULE12
                  || (role_reg == sync_cmd_pkg::MODE_GPS_PRI
                      && (count_reg == 8'h00 || !pps_lost)); // see RULE13 see RULE14

  always_comb begin
    take_next   = take_reg;
    bo_act_next = bo_act_reg;
    bo_cnt_next = bo_cnt_reg;
    if (role_write || base_gen) begin
      take_next   = 1'b0;
      bo_act_next = 1'b0;
    end else if (bo_act_reg) begin
      // a pulse from a lower count during backoff keeps us a follower
      if (sync_edge) begin // see RULE17
        bo_act_next = 1'b0;
      end else if (bo_cnt_reg == '0) begin
        bo_act_next = 1'b0;
        take_next   = 1'b1; // see RULE12 see RULE13
      end else begin
        bo_cnt_next = bo_cnt_reg - 1'b1;
      end
    end else if (!take_reg && sync_lost && count_reg != 8'h00) begin // see RULE10
      bo_act_next = 1'b1;
      bo_cnt_next = sync_cmd_pkg::CNT_W'(count_reg * SLOT_CYC); // see RULE17
    end
  end

  assign fire = gen_reg && ((per_cnt_reg == sync_cmd_pkg::CNT_W'(SYNC_PERIOD_CYC - 1))
                || (role_reg == sync_cmd_pkg::MODE_GPS_PRI && pps_edge));

  always_comb begin
    gen_next       = base_gen || take_reg;
    per_cnt_next   = per_cnt_reg;
    pulse_cnt_next = pulse_cnt_reg;
    if (!gen_reg || fire) begin
      per_cnt_next = '0;
    end else begin
      per_cnt_next = per_cnt_reg + 1'b1;
    end
    if (fire) begin
      pulse_cnt_next = sync_cmd_pkg::CNT_W'(PULSE_CYC);
    end else if (pulse_cnt_reg != '0) begin
      pulse_cnt_next = pulse_cnt_reg - 1'b1;
    end
    drive_next = pulse_cnt_next != '0;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gen_reg       <= 1'b0;
      take_reg      <= 1'b0;
      bo_act_reg    <= 1'b0;
      bo_cnt_reg    <= '0;
      per_cnt_reg   <= '0;
      pulse_cnt_reg <= '0;
      drive_reg     <= 1'b0;
    end else begin
      gen_reg       <= gen_next;
      take_reg      <= take_next;
      bo_act_reg    <= bo_act_next;
      bo_cnt_reg    <= bo_cnt_next;
      per_cnt_reg   <= per_cnt_next;
      pulse_cnt_reg <= pulse_cnt_next;
      drive_reg     <= drive_next;
    end
  end

  assign tx_valid      = tx_valid_reg;
  assign tx_byte       = tx_byte_reg;
  assign sync_role     = role_reg;
  assign slave_count   = count_reg;
  assign pulse_master  = gen_reg;
  assign mode_rejected = reject_reg;
  // registered so the shared pin never sees a compare glitch
  assign sync_out      = drive_reg;
  assign sync_oe       = drive_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  first_byte_a: // see RULE2
    assert property (state_reg == sync_cmd_pkg::ST_ARG1 && rx_valid
                     |=> tx_valid && tx_byte == sync_cmd_pkg::CODE_HI)
    else $error("response does not open with high code byte");

  echo_low_a: // see RULE9
    assert property (tx_valid && tx_ready && idx_reg == '0 |=> tx_byte == cmd_reg)
    else $error("second response byte is not the command low byte");

  role_len_a: // see RULE9
    assert property (tx_valid && tx_ready && idx_reg == sync_cmd_pkg::ROLE_LAST_IDX
                     && cmd_reg == sync_cmd_pkg::CODE_ROLE_LO |=> !tx_valid)
    else $error("role answer carries payload");

  reserved_zero_a: // see RULE2
    assert property (tx_valid && cmd_reg == sync_cmd_pkg::CODE_QUERY_LO
                     && idx_reg == sync_cmd_pkg::IDX_RESERVED |-> tx_byte == 8'h00)
    else $error("reserved byte not zero");

  ack_field_a: // see RULE4
    assert property (tx_valid && cmd_reg == sync_cmd_pkg::CODE_QUERY_LO
                     && idx_reg == sync_cmd_pkg::IDX_SEQ
                     |-> tx_byte[3:1] == 3'h0 && tx_byte == seq_reg)
    else $error("configuration field out of range");
  antenna_range_a: // see RULE5
    assert property (tx_valid && idx_reg == sync_cmd_pkg::QUERY_LAST_IDX
                     |-> tx_byte <= sync_cmd_pkg::ANTENNA_MAX)
    else $error("antenna number out of range");
  count_limit_a: // see RULE11
    assert property (count_reg <= sync_cmd_pkg::MAX_COUNT)
    else $error("slave select count above limit");
  one_role_a: // see RULE7
    assert property ($onehot0(role_reg))
    else $error("more than one role active");
  reject_keeps_a: // see RULE11
    assert property (mode_rejected |-> $stable(count_reg) && $stable(role_reg))
    else $error("rejected setting was stored");
  master_leads_a: // see RULE12
    assert property (role_reg == sync_cmd_pkg::MODE_MASTER && count_reg == 8'h00
                     && !role_write ##1 $stable(role_reg) |-> gen_reg)
    else $error("master with count zero is not generating");
  takeover_wait_a: // see RULE17
    assert property ($rose(take_reg) |-> $past(bo_act_reg) && $past(bo_cnt_reg) == '0)
    else $error("takeover without full backoff");
  pulse_drive_a: // see RULE10
    assert property (fire |=> sync_oe && sync_out [*2])
    else $error("fire did not drive the sync pin");

  query_done_c:    cover property (state_reg == sync_cmd_pkg::ST_SEND && tx_ready
                                   && idx_reg == sync_cmd_pkg::QUERY_LAST_IDX);
  role_set_c:      cover property (role_write);
  takeover_c:      cover property ($rose(take_reg));
  reject_c:        cover property (mode_rejected);

endmodule

// ==== bench/peer_sync_model.sv ====
`timescale 1ns/1ps
module peer_sync_model #(
  parameter int PERIOD = 200,
  parameter int WIDTH  = 20
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // control and drive
  input  wire logic run,
  output logic      pulse
);
  int cnt_reg;

  // width stays well under the period so successive pulses never merge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg <= 0;
      pulse   <= 1'b0;
    end else begin
      cnt_reg <= (cnt_reg == PERIOD - 1) ? 0 : cnt_reg + 1;
      pulse   <= run && (cnt_reg < WIDTH);
    end
  end
endmodule

// ==== bench/tb.sv ====
`timescale 1ns/1ps
module tb;
  localparam int PER  = 200;
  localparam int LOSS = 500;
  localparam int SLOT = 50;

  logic       clk;
  logic       reset_n;
  logic       rx_valid;
  logic [7:0] rx_byte;
  logic       tx_ready;
  logic       tx_valid;
  logic [7:0] tx_byte;
  logic [3:0] seq_protocol;
  logic       seq_ack;
  logic [1:0] seq_antenna;
  logic       sync_out;
  logic       sync_oe;
  logic [3:0] sync_role;
  logic [7:0] slave_count;
  logic       pulse_master;
  logic       mode_rejected;
  logic       peer_run;
  logic       peer_pulse;
  logic       pps_run;
  logic       pps_pulse;
  wire        sync_wire = peer_pulse | (sync_oe & sync_out);
  int         err_count;
  int         total_checks;
  int         i;

  sync_cmd_unit #(
    .SYNC_PERIOD_CYC(PER), .SYNC_LOSS_CYC(LOSS), .PPS_LOSS_CYC(1000), .SLOT_CYC(SLOT),
    .PULSE_CYC(20)
  ) dut (
    .clk(clk), .reset_n(reset_n), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_byte(tx_byte),
    .seq_protocol(seq_protocol), .seq_ack(seq_ack), .seq_antenna(seq_antenna),
    .sync_in(sync_wire), .sync_out(sync_out), .sync_oe(sync_oe), .pps_in(pps_pulse),
    .sync_role(sync_role), .slave_count(slave_count), .pulse_master(pulse_master),
    .mode_rejected(mode_rejected)
  );

  peer_sync_model #(.PERIOD(PER), .WIDTH(20)) peer (
    .clk(clk), .reset_n(reset_n), .run(peer_run), .pulse(peer_pulse)
  );

  peer_sync_model #(.PERIOD(500), .WIDTH(10)) gps (
    .clk(clk), .reset_n(reset_n), .run(pps_run), .pulse(pps_pulse)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      err_count++;
    end
  endtask

  task automatic send_cmd(input logic [31:0] w);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      #2;
      rx_valid = 1'b1;
      rx_byte  = w[31-8*k-:8];
    end
    @(posedge clk);
    #2;
    rx_valid = 1'b0;
  endtask

  // expects tx_ready high; one byte leaves per handshake edge
  task automatic get_rsp(input string name, input int n, input logic [39:0] exp);
    int k;
    for (int b = 0; b < n; b++) begin
      for (k = 0; k < 50 && tx_valid !== 1'b1; k++) begin
        @(posedge clk);
        #2;
      end
      if (k == 50) begin
        err_count++;
        conclude();
      end
      check(name, exp[39-8*b-:8], tx_byte);
      @(posedge clk);
      #2;
    end
    check("tx_valid after response", 8'h00, {7'h00, tx_valid});
  endtask

  // host is stalled during the command so the echo must wait for it
  task automatic set_role(input logic [7:0] mode, input logic [7:0] cnt, input logic rej);
    int k;
    tx_ready = 1'b0;
    send_cmd({8'h00, 8'h45, mode, cnt});
    for (k = 0; k < 3 && mode_rejected !== 1'b1; k++) begin
      @(posedge clk);
      #2;
    end
    check("reject flag", {7'h00, rej}, {7'h00, mode_rejected});
    repeat (2) @(posedge clk);
    #2;
    check("reject pulse end", 8'h00, {7'h00, mode_rejected});
    tx_ready = 1'b1;
    get_rsp("role echo", 2, {8'h00, 8'h45, 24'h000000});
  endtask

  task automatic wait_pm(input string name, input int lim);
    int k;
    for (k = 0; k < lim && pulse_master !== 1'b1; k++) begin
      @(posedge clk);
      #2;
    end
    check(name, 8'h01, {7'h00, pulse_master});
    if (pulse_master !== 1'b1) begin
      conclude();
    end
  endtask

  task automatic hold_pm0(input string name, input int n);
    int k;
    for (k = 0; k < n && pulse_master === 1'b0; k++) begin
      @(posedge clk);
      #2;
    end
    check(name, 8'h00, {7'h00, pulse_master});
  endtask

  task automatic wait_peer(input logic lvl);
    int k;
    for (k = 0; k < 400 && peer_pulse !== lvl; k++) begin
      @(posedge clk);
      #2;
    end
    if (k == 400) begin
      err_count++;
      conclude();
    end
  endtask

  initial begin
    err_count    = 0;
    total_checks = 0;
    reset_n      = 1'b0;
    rx_valid     = 1'b0;
    rx_byte      = 8'h00;
    tx_ready     = 1'b1;
    seq_protocol = 4'h4;
    seq_ack      = 1'b0;
    seq_antenna  = 2'h0;
    peer_run     = 1'b0;
    pps_run      = 1'b0;
    repeat (20) @(posedge clk);
    #2;
    reset_n = 1'b1;
    check("role after reset", 8'h00, {4'h0, sync_role});
    check("count after reset", 8'h00, slave_count);
    check("pulse_master after reset", 8'h00, {7'h00, pulse_master});
    for (i = 0; i < 4; i++) begin
      seq_ack     = i[0];
      seq_antenna = 2'(i);
      send_cmd({8'h00, 8'h41, 8'h04, 8'(i)});
      get_rsp("query", 5, {16'h0041, 8'h00, 4'h4, 3'h0, i[0], 6'h00, 2'(i)});
    end
    set_role(8'h03, 8'h01, 1'b1);
    set_role(8'h00, 8'h01, 1'b1);
    set_role(8'h01, 8'h1B, 1'b1);
    check("role kept", 8'h00, {4'h0, sync_role});
    check("count kept", 8'h00, slave_count);
    // upper mode bits are reserved and must not spoil a valid role
    set_role(8'h11, 8'h1A, 1'b0);
    check("slave role", 8'h01, {4'h0, sync_role});
    check("count 26", 8'h1A, slave_count);
    set_role(8'h01, 8'h00, 1'b0);
    hold_pm0("slave count 0", 2000);
    // a live edge must clear the loss flag before a nonzero count lands
    peer_run = 1'b1;
    wait_peer(1'b1);
    set_role(8'h01, 8'h03, 1'b0);
    hold_pm0("slave under live sync", 1000);
    wait_peer(1'b1);
    wait_peer(1'b0);
    peer_run = 1'b0;
    // takeover lands about LOSS + 3 * SLOT - 14 cycles after the last falling edge
    hold_pm0("slave before its slot", LOSS + 3 * SLOT - 30);
    wait_pm("slave takeover", 40);
    for (i = 0; i < PER + 20 && sync_oe !== 1'b1; i++) begin
      @(posedge clk);
      #2;
    end
    check("pulse drive", 8'h01, {7'h00, sync_oe});
    check("pulse level", 8'h01, {7'h00, sync_out});
    if (sync_oe !== 1'b1) begin
      conclude();
    end
    set_role(8'h02, 8'h00, 1'b0);
    wait_pm("master count 0", 10);
    pps_run = 1'b1;
    set_role(8'h08, 8'h00, 1'b0);
    wait_pm("gps primary", 10);
    pps_run = 1'b0;
    set_role(8'h04, 8'h01, 1'b0);
    check("secondary role", 8'h04, {4'h0, sync_role});
    check("secondary follows", 8'h00, {7'h00, pulse_master});
    wait_pm("secondary takeover", 8000);
    // a changed sequence is sampled at the next query; the reset here only follows RULE16
    seq_ack     = 1'b1;
    seq_antenna = 2'h3;
    reset_n     = 1'b0;
    repeat (3) @(posedge clk);
    #2;
    reset_n = 1'b1;
    check("role after second reset", 8'h00, {4'h0, sync_role});
    check("count after second reset", 8'h00, slave_count);
    check("pulse_master after second reset", 8'h00, {7'h00, pulse_master});
    check("tx_valid after second reset", 8'h00, {7'h00, tx_valid});
    check("sync_oe after second reset", 8'h00, {7'h00, sync_oe});
    send_cmd({8'h00, 8'h41, 8'h04, 8'h03});
    get_rsp("query after reset", 5, {16'h0041, 8'h00, 8'h41, 8'h03});
    conclude();
  end
endmodule
